// [oapd_loader.sv]
// Application parameter loader, decoder and coil current sequencer.
`timescale 1ns/100ps
// How it works
// R1: Parameter write replaces the working parameter copy; the physical address bits and the bank bit are kept.
// R2: Node address is the four stored bits joined with three hardwired inputs.
// R3: Stall index zero disables stall detection; other codes select a threshold.
// R4: Three-bit select picks one of eight stop and recovery voltage pairs.
// R5: Run index picks coil amplitude; boost flag selects the boost table.
// R6: Hold index uses run steps; code F means zero hold current.
// R7: On motion stop the setpoint drops from run to hold index.
// R8: Hold code F first goes to code 0, then PWM off, low side grounded.
// R9: Shaft bit selects clockwise or counter-clockwise rotation.
// R10: Lost link or error overflow sends the motor to the safe position.
// R11: Reserved safe pattern disables lost-link and dual move, not explicit goto.
// R12: Safe position is eleven upper bits; two lowest load as zero.
// R13: Bank bit picks bytes 5 and 6 or bytes 8 and 9 as source.
// R14: With bank bit set, readback of bytes 5 and 6 returns 8 and 9.
// R15: Step field selects half, quarter, eighth or sixteenth stepping.
// R16: Parameters load once after reset; later image changes need a new reset.
// R17: On link timeout sleep if allowed, else stay stopped with hold current.
module oapd_loader (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_ce,
  input  wire oapd_pkg::oapd_image_t i_nv_image,
  input  wire logic [2:0]           i_hardwired_addr_inputs,
  input  wire logic                 i_motor_param_write_cmd,
  input  wire oapd_pkg::oapd_param_s i_param_wdata,
  input  wire logic                 i_nonvolatile_readback_cmd,
  input  wire logic [3:0]           i_readback_addr,
  input  wire logic                 i_motion_running,
  input  wire logic                 i_boost_active,
  input  wire logic                 i_link_lost,
  input  wire logic                 i_err_count_overflow,
  input  wire logic                 i_goto_safe_position_cmd,
  input  wire logic                 i_link_timeout,
  output logic                      o_loaded,
  output oapd_pkg::oapd_param_s     o_param,
  output logic [6:0]                o_node_addr,
  output logic                      o_stall_detect_en,
  output logic [3:0]                o_coil_current_index,
  output logic                      o_coil_boost,
  output logic                      o_pwm_enable,
  output logic                      o_lowside_ground,
  output logic                      o_dir_ccw,
  output logic [15:0]               o_safe_target,
  output logic                      o_goto_safe,
  output logic                      o_dual_move_safe_en,
  output logic                      o_sleep_req,
  output logic                      o_hold_stop_req,
  output logic [7:0]                o_readback_data,
  output logic                      o_readback_valid
);
  // ----------------------------------------------------------------------
  // Load and working copy
  // ----------------------------------------------------------------------
  oapd_pkg::oapd_param_s par_ff;
  oapd_pkg::oapd_param_s nxt_par;
  logic [3:0]            pa_ff;
  logic [3:0]            nxt_pa;
  logic                  bank_ff;
  logic                  nxt_bank;
  logic                  loaded_ff;
  logic                  nxt_loaded;
  logic [7:0]            src_h;
  logic [7:0]            src_l;
  logic                  nv_bank;
  always_comb
  begin
    nxt_par    = par_ff;
    nxt_pa     = pa_ff;
    nxt_bank   = bank_ff;
    nxt_loaded = loaded_ff;
    nv_bank    = i_nv_image[oapd_pkg::ADDR_BANK][oapd_pkg::BIT_BANK];
    src_h      = nv_bank ? i_nv_image[oapd_pkg::ADDR_ALT_H] : i_nv_image[oapd_pkg::ADDR_SAFE_H]; // R13
    src_l      = nv_bank ? i_nv_image[oapd_pkg::ADDR_ALT_L] : i_nv_image[oapd_pkg::ADDR_SAFE_L]; // R13
    if (!loaded_ff) // R16
    begin
      nxt_loaded = 1'b1;
      nxt_bank   = nv_bank;
      nxt_pa     = i_nv_image[oapd_pkg::ADDR_THRPA][oapd_pkg::POS_PA +: 4];
      nxt_par.stall_threshold_index     = i_nv_image[oapd_pkg::ADDR_THRPA][oapd_pkg::POS_THR +: 4];
      nxt_par.irun                      = i_nv_image[oapd_pkg::ADDR_CURR][oapd_pkg::POS_IRUN +: 4];
      nxt_par.ihold                     = i_nv_image[oapd_pkg::ADDR_CURR][oapd_pkg::POS_IHOLD +: 4];
      nxt_par.shaft                     = i_nv_image[oapd_pkg::ADDR_SAFE_H][oapd_pkg::BIT_SHAFT];
      nxt_par.safe_target_position      = {src_h[oapd_pkg::POS_SAFE_H +: 3],
                                           src_l[oapd_pkg::POS_SAFE_L +: 6],
                                           oapd_pkg::SAFE_LSB_ZERO}; // R12
      nxt_par.failsafe                  = src_l[oapd_pkg::BIT_FAILSAFE];
      nxt_par.auto_sleep_allow          = src_l[oapd_pkg::BIT_SLEEP];
      nxt_par.undervoltage_level_select = i_nv_image[oapd_pkg::ADDR_MODE][oapd_pkg::POS_UVSEL +: 3];
      nxt_par.microstep_resolution      =
        oapd_pkg::oapd_step_e'(i_nv_image[oapd_pkg::ADDR_MODE][oapd_pkg::POS_STEP +: 2]); // R15
    end
    else if (i_motor_param_write_cmd)
    begin
      nxt_par = i_param_wdata; // R1
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      par_ff    <= oapd_pkg::PARAM_RESET;
      pa_ff     <= 4'h0;
      bank_ff   <= 1'b0;
      loaded_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      par_ff    <= nxt_par;
      pa_ff     <= nxt_pa;
      bank_ff   <= nxt_bank;
      loaded_ff <= nxt_loaded;
    end
  end

  // ----------------------------------------------------------------------
  // Coil current sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CUR_RUN,
    CUR_HOLD,
    CUR_DRAIN,
    CUR_OFF
  } oapd_cur_e;
  oapd_cur_e  cur_ff;
  oapd_cur_e  nxt_cur;
  logic [7:0] settle_ff;
  logic [7:0] nxt_settle;
  logic [3:0] idx_ff;
  logic [3:0] nxt_idx;
  logic       pwm_ff;
  logic       nxt_pwm;
  logic       gnd_ff;
  logic       nxt_gnd;
  always_comb
  begin
    nxt_cur    = cur_ff;
    nxt_settle = settle_ff;
    case (cur_ff)
      CUR_RUN:
      begin
        nxt_settle = 8'h00;
        if (!i_motion_running && loaded_ff) // R7
          nxt_cur = (par_ff.ihold == oapd_pkg::HOLD_ZERO) ? CUR_DRAIN : CUR_HOLD; // R6
      end
      CUR_HOLD:
      begin
        if (i_motion_running)
          nxt_cur = CUR_RUN;
        else if (par_ff.ihold == oapd_pkg::HOLD_ZERO)
          nxt_cur = CUR_DRAIN;
      end
      CUR_DRAIN:
      begin
        nxt_settle = settle_ff + 8'h01;
        if (i_motion_running)
          nxt_cur = CUR_RUN;
        else if (settle_ff == oapd_pkg::SETTLE_LAST) // R8
          nxt_cur = CUR_OFF;
      end
      CUR_OFF:
      begin
        if (i_motion_running)
          nxt_cur = CUR_RUN;
        else if (par_ff.ihold != oapd_pkg::HOLD_ZERO)
          nxt_cur = CUR_HOLD;
      end
      default:
        nxt_cur = CUR_RUN;
    endcase
    case (nxt_cur)
      CUR_RUN:   nxt_idx = par_ff.irun; // R5
      CUR_HOLD:  nxt_idx = par_ff.ihold; // R7
      default:   nxt_idx = oapd_pkg::CUR_LOWEST; // R8
    endcase
    nxt_pwm = (nxt_cur != CUR_OFF); // R8
    nxt_gnd = (nxt_cur == CUR_OFF); // R8
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      cur_ff    <= CUR_RUN;
      settle_ff <= 8'h00;
      idx_ff    <= 4'h0;
      pwm_ff    <= 1'b0;
      gnd_ff    <= 1'b0;
    end
    else if (i_ce)
    begin
      cur_ff    <= nxt_cur;
      settle_ff <= nxt_settle;
      idx_ff    <= nxt_idx;
      pwm_ff    <= nxt_pwm;
      gnd_ff    <= nxt_gnd;
    end
  end

  // ----------------------------------------------------------------------
  // Safe position, sleep and readback
  // ----------------------------------------------------------------------
  logic       safe_off;
  logic       goto_ff;
  logic       nxt_goto;
  logic       sleep_ff;
  logic       nxt_sleep;
  logic       hstop_ff;
  logic       nxt_hstop;
  logic [7:0] rb_ff;
  logic [7:0] nxt_rb;
  logic       rbv_ff;
  logic       nxt_rbv;
  logic [3:0] rb_addr;
  always_comb
  begin
    safe_off  = (par_ff.safe_target_position[10:2] == oapd_pkg::SAFE_DISABLED); // R11
    nxt_goto  = loaded_ff && (i_goto_safe_position_cmd ||
                ((i_link_lost || i_err_count_overflow) && !safe_off)); // R10
    nxt_sleep = loaded_ff && i_link_timeout && par_ff.auto_sleep_allow; // R17
    nxt_hstop = loaded_ff && i_link_timeout && !par_ff.auto_sleep_allow; // R17
    rb_addr   = i_readback_addr;
    if (bank_ff && (i_readback_addr == oapd_pkg::ADDR_SAFE_H)) // R14
      rb_addr = oapd_pkg::ADDR_ALT_H;
    else if (bank_ff && (i_readback_addr == oapd_pkg::ADDR_SAFE_L)) // R14
      rb_addr = oapd_pkg::ADDR_ALT_L;
    nxt_rbv   = i_nonvolatile_readback_cmd;
    nxt_rb    = rb_ff;
    if (i_nonvolatile_readback_cmd)
      nxt_rb  = (rb_addr < 4'(oapd_pkg::NV_BYTES)) ? i_nv_image[rb_addr] : oapd_pkg::BYTE_RESET;
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      goto_ff  <= 1'b0;
      sleep_ff <= 1'b0;
      hstop_ff <= 1'b0;
      rb_ff    <= 8'h00;
      rbv_ff   <= 1'b0;
    end
    else if (i_ce)
    begin
      goto_ff  <= nxt_goto;
      sleep_ff <= nxt_sleep;
      hstop_ff <= nxt_hstop;
      rb_ff    <= nxt_rb;
      rbv_ff   <= nxt_rbv;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------------
  logic [6:0]  addr_ff;
  logic        stall_ff;
  logic        boost_ff;
  logic        dir_ff;
  logic [15:0] safe_ff;
  logic        dual_ff;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      addr_ff  <= 7'h00;
      stall_ff <= 1'b0;
      boost_ff <= 1'b0;
      dir_ff   <= 1'b0;
      safe_ff  <= 16'h0000;
      dual_ff  <= 1'b0;
    end
    else if (i_ce)
    begin
      addr_ff  <= {nxt_pa, i_hardwired_addr_inputs}; // R2
      stall_ff <= (nxt_par.stall_threshold_index != oapd_pkg::STALL_OFF); // R3
      boost_ff <= i_boost_active; // R5
      dir_ff   <= nxt_par.shaft; // R9
      safe_ff  <= {nxt_par.safe_target_position, oapd_pkg::POS_PAD_ZERO}; // R12
      dual_ff  <= (nxt_par.safe_target_position[10:2] != oapd_pkg::SAFE_DISABLED); // R11
    end
  end
  assign o_loaded             = loaded_ff;
  assign o_param              = par_ff; // R4
  assign o_node_addr          = addr_ff;
  assign o_stall_detect_en    = stall_ff;
  assign o_coil_current_index = idx_ff;
  assign o_coil_boost         = boost_ff;
  assign o_pwm_enable         = pwm_ff;
  assign o_lowside_ground     = gnd_ff;
  assign o_dir_ccw            = dir_ff;
  assign o_safe_target        = safe_ff;
  assign o_goto_safe          = goto_ff;
  assign o_dual_move_safe_en  = dual_ff;
  assign o_sleep_req          = sleep_ff;
  assign o_hold_stop_req      = hstop_ff;
  assign o_readback_data      = rb_ff;
  assign o_readback_valid     = rbv_ff;
endmodule : oapd_loader

// [oapd_pkg.sv]
// Package with constants and types for the application parameter loader.
package oapd_pkg;

  // ----------------------------------------------------------------------
  // Non-volatile byte addresses
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_BANK   = 4'h0;
  localparam logic [3:0] ADDR_THRPA  = 4'h2;
  localparam logic [3:0] ADDR_CURR   = 4'h3;
  localparam logic [3:0] ADDR_SAFE_H = 4'h5;
  localparam logic [3:0] ADDR_SAFE_L = 4'h6;
  localparam logic [3:0] ADDR_MODE   = 4'h7;
  localparam logic [3:0] ADDR_ALT_H  = 4'h8;
  localparam logic [3:0] ADDR_ALT_L  = 4'h9;
  localparam int         NV_BYTES    = 10;

  // ----------------------------------------------------------------------
  // Field positions inside the bytes
  // ----------------------------------------------------------------------
  localparam int BIT_BANK      = 7;
  localparam int POS_THR       = 4;
  localparam int POS_PA        = 0;
  localparam int POS_IRUN      = 4;
  localparam int POS_IHOLD     = 0;
  localparam int POS_SAFE_H    = 5;
  localparam int BIT_SHAFT     = 4;
  localparam int POS_SAFE_L    = 2;
  localparam int BIT_FAILSAFE  = 1;
  localparam int BIT_SLEEP     = 0;
  localparam int POS_UVSEL     = 4;
  localparam int POS_STEP      = 2;

  // ----------------------------------------------------------------------
  // Codes, reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [3:0]  STALL_OFF      = 4'h0;
  localparam logic [3:0]  HOLD_ZERO      = 4'hF;
  localparam logic [3:0]  CUR_LOWEST     = 4'h0;
  localparam logic [8:0]  SAFE_DISABLED  = 9'h100;
  localparam logic [1:0]  SAFE_LSB_ZERO  = 2'h0;
  localparam logic [4:0]  POS_PAD_ZERO   = 5'h00;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam int          CLK_MHZ        = 100;
  localparam int          SETTLE_NS      = 1000;
  localparam int          SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  SETTLE_LAST    = 8'(SETTLE_CYC - 1);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    STEP_HALF,
    STEP_QUARTER,
    STEP_EIGHTH,
    STEP_SIXTEENTH
  } oapd_step_e;

  typedef struct packed {
    logic [3:0]  stall_threshold_index;
    logic [2:0]  undervoltage_level_select;
    logic [3:0]  irun;
    logic [3:0]  ihold;
    logic        shaft;
    logic [10:0] safe_target_position;
    logic        failsafe;
    logic        auto_sleep_allow;
    oapd_step_e  microstep_resolution;
  } oapd_param_s;

  localparam oapd_param_s PARAM_RESET = '0;

  typedef logic [NV_BYTES-1:0][7:0] oapd_image_t;

endpackage : oapd_pkg

// [oapd_checker.sv]
// Checker with port assertions for the parameter loader.
`timescale 1ns/100ps
module oapd_checker (
  input wire logic                  i_core_clk,
  input wire logic                  i_rst_n,
  input wire oapd_pkg::oapd_image_t i_nv_image,
  input wire logic [2:0]            i_hardwired_addr_inputs,
  input wire logic                  i_nonvolatile_readback_cmd,
  input wire logic [3:0]            i_readback_addr,
  input wire logic                  i_motion_running,
  input wire logic                  i_link_lost,
  input wire logic                  i_err_count_overflow,
  input wire logic                  i_goto_safe_position_cmd,
  input wire logic                  i_link_timeout,
  input wire logic                  o_loaded,
  input wire oapd_pkg::oapd_param_s o_param,
  input wire logic [6:0]            o_node_addr,
  input wire logic                  o_stall_detect_en,
  input wire logic [3:0]            o_coil_current_index,
  input wire logic                  o_pwm_enable,
  input wire logic                  o_lowside_ground,
  input wire logic                  o_dir_ccw,
  input wire logic [15:0]           o_safe_target,
  input wire logic                  o_goto_safe,
  input wire logic                  o_dual_move_safe_en,
  input wire logic                  o_sleep_req,
  input wire logic                  o_hold_stop_req,
  input wire logic [7:0]            o_readback_data,
  input wire logic                  o_readback_valid
);
  // ----------------------------------------------------------------------
  // Drain counter and properties
  // ----------------------------------------------------------------------
  logic [7:0] drain_ff;
  logic [7:0] nxt_drain;
  logic       run_q_ff;
  logic       nxt_run_q;
  always_comb
  begin
    nxt_run_q = i_motion_running;
    nxt_drain = 8'h00;
    if (o_loaded && !i_motion_running && o_param.ihold == 4'hF && (run_q_ff || drain_ff != 8'h00))
      nxt_drain = drain_ff + 8'(drain_ff != 8'hFF);
  end
  always_ff @(posedge i_core_clk)
  begin
    run_q_ff <= i_rst_n && nxt_run_q;
    drain_ff <= i_rst_n ? nxt_drain : 8'h00;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_stop_zero;
    $fell(i_motion_running) && o_param.ihold == 4'hF && o_loaded;
  endsequence
  a_zero_first: assert property (s_stop_zero |=> o_coil_current_index == 4'h0 && o_pwm_enable)
    else $error("zero hold did not start at lowest current");
  a_drain_wait: assert property (drain_ff inside {[2:90]} |-> o_pwm_enable && !o_lowside_ground)
    else $error("regulator switched off too early");
  a_drain_off: assert property (drain_ff >= 8'd110 |-> !o_pwm_enable && o_lowside_ground)
    else $error("regulator not switched off after drain");
  a_hold_index: assert property ($fell(i_motion_running) && o_param.ihold != 4'hF && o_loaded
    |=> o_coil_current_index == $past(o_param.ihold))
    else $error("hold index not applied on stop");
  a_run_index: assert property ($rose(i_motion_running) && o_loaded
    |=> o_coil_current_index == $past(o_param.irun))
    else $error("run index not applied on start");
  a_node_addr: assert property (o_loaded |-> o_node_addr == {i_nv_image[2][3:0], $past(i_hardwired_addr_inputs)})
    else $error("node address wrong");
  a_stall_off: assert property (o_loaded |-> o_stall_detect_en == (o_param.stall_threshold_index != 4'h0))
    else $error("stall enable wrong");
  a_dir_shaft: assert property (o_loaded |-> o_dir_ccw == o_param.shaft)
    else $error("direction wrong");
  a_safe_pad: assert property (o_loaded |-> o_safe_target == {o_param.safe_target_position, 5'h00})
    else $error("safe target wrong");
  a_dual_off: assert property (o_loaded
    |-> o_dual_move_safe_en == (o_param.safe_target_position[10:2] != 9'h100))
    else $error("dual move enable wrong");
  a_safe_goto: assert property (o_loaded && (i_goto_safe_position_cmd ||
    ((i_link_lost || i_err_count_overflow) && o_dual_move_safe_en)) |=> o_goto_safe)
    else $error("safe move not requested");
  a_bank_read: assert property (i_nonvolatile_readback_cmd && o_loaded && i_nv_image[0][7]
    && i_readback_addr == 4'h5 |=> o_readback_valid && o_readback_data == i_nv_image[8])
    else $error("bank readback not remapped");
  a_sleep_pick: assert property (i_link_timeout && o_loaded
    |=> o_sleep_req == $past(o_param.auto_sleep_allow) && o_hold_stop_req != $past(o_param.auto_sleep_allow))
    else $error("timeout reaction wrong");
endmodule : oapd_checker

bind oapd_loader oapd_checker u_chk (.*);

// [oapd_lin_master.sv]
// Bus master model that issues commands to the loader.
`timescale 1ns/100ps
module oapd_lin_master (
  input  wire logic             i_clk,
  output oapd_pkg::oapd_param_s o_wdata,
  output logic                  o_wr,
  output logic                  o_rd,
  output logic [3:0]            o_addr,
  output logic [3:0]            o_ev
);
  // ----------------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------------
  initial
  begin
    o_wdata = '0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 4'h0;
    o_ev = 4'h0;
  end
  task automatic send(input logic w, input oapd_pkg::oapd_param_s p, input logic [3:0] e);
    @(negedge i_clk);
    o_wr = w;
    o_wdata = p;
    o_ev = e;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~p;
    o_ev = 4'h0;
  endtask : send
  task automatic burst_read(input int a0, input int a1);
    for (int a = a0; a <= a1; a++)
    begin
      @(negedge i_clk);
      o_rd = 1'b1;
      o_addr = 4'(a);
    end
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~o_addr;
  endtask : burst_read
endmodule : oapd_lin_master

// [oapd_loader_tb.sv]
// Self-checking testbench for the parameter loader.
`timescale 1ns/100ps
module oapd_loader_tb;
  // ----------------------------------------------------------------------
  // Stimulus, scoreboard and verdict
  // ----------------------------------------------------------------------
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  ce = 1'b1;
  logic                  run = 1'b0;
  logic                  boost = 1'b0;
  logic [2:0]            hw = 3'h0;
  logic                  wr, rd, ld, sen, cb, pwm, gnd, ccw, gs, dme, slp, hsr, rbv;
  logic [3:0]            addr, ev, ci;
  logic [6:0]            na;
  logic [7:0]            rbd;
  logic [15:0]           st;
  logic [7:0]            rbq[$];
  oapd_pkg::oapd_image_t img = '0;
  oapd_pkg::oapd_param_s p, ep, wd, op;
  int                    mismatches = 0;
  int                    compares = 0;
  always #5 clk = ~clk;
  oapd_lin_master lin (.i_clk(clk), .o_wdata(wd), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_ev(ev));
  oapd_loader dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_nv_image(img), .i_hardwired_addr_inputs(hw),
    .i_motor_param_write_cmd(wr), .i_param_wdata(wd), .i_nonvolatile_readback_cmd(rd), .i_readback_addr(addr),
    .i_motion_running(run), .i_boost_active(boost), .i_link_lost(ev[0]), .i_err_count_overflow(ev[1]),
    .i_goto_safe_position_cmd(ev[2]), .i_link_timeout(ev[3]), .o_loaded(ld), .o_param(op), .o_node_addr(na),
    .o_stall_detect_en(sen), .o_coil_current_index(ci), .o_coil_boost(cb), .o_pwm_enable(pwm),
    .o_lowside_ground(gnd), .o_dir_ccw(ccw), .o_safe_target(st), .o_goto_safe(gs), .o_dual_move_safe_en(dme),
    .o_sleep_req(slp), .o_hold_stop_req(hsr), .o_readback_data(rbd), .o_readback_valid(rbv));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", n, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("Counts compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk("param_in_reset", op, 0);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    ep = {img[2][7:4], img[7][6:4], img[3], img[5][4],
      img[0][7] ? {img[8][7:5], img[9][7:2], 2'b00, img[9][1:0]} : {img[5][7:5], img[6][7:2], 2'b00, img[6][1:0]},
      img[7][3:2]};
    chk("loaded", ld, 1'b1);
    chk("param", op, ep);
    chk("node_addr", na, {img[2][3:0], hw});
    chk("safe_target", st, {ep.safe_target_position, 5'h00});
    $display("Test reset load done");
  endtask : do_reset
  always @(negedge clk)
    if (rbv === 1'b1)
      chk("readback_data", rbd, rbq.size() > 0 ? rbq.pop_front() : 8'hXX);
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'h8f7d));
    hw = 3'($urandom);
    for (int k = 0; k < 10; k++)
      img[k] = 8'($urandom);
    img[0][7] = 1'b1;
    do_reset();
    for (int a = 0; a < 11; a++)
      rbq.push_back(a == 5 ? img[8] : a == 6 ? img[9] : a < 10 ? img[a] : 8'h00);
    lin.burst_read(0, 10);
    repeat (2) @(negedge clk);
    chk("readback_all", rbq.size(), 0);
    $display("Test readback done");
    for (int s = 0; s < 8; s++)
    begin
      p = 31'($urandom);
      p.microstep_resolution = oapd_pkg::oapd_step_e'(s % 4);
      p.undervoltage_level_select = 3'(s);
      p.stall_threshold_index = s == 7 ? 4'hF : 4'(s * 2);
      p.safe_target_position = 11'h2A4;
      lin.send(1'b1, p, 4'h0);
      chk("param_write", op, p);
      chk("stall_en", sen, s != 0);
      chk("node_kept", na, {img[2][3:0], hw});
      chk("dir", ccw, p.shaft);
    end
    for (int e = 0; e < 3; e++)
    begin
      lin.send(1'b0, p, 4'(1 << e));
      chk("safe_goto", gs, 1'b1);
    end
    p.safe_target_position = 11'h400;
    lin.send(1'b1, p, 4'h0);
    chk("dual_off", dme, 1'b0);
    lin.send(1'b0, p, 4'h1);
    chk("lost_blocked", gs, 1'b0);
    lin.send(1'b0, p, 4'h4);
    chk("goto_reserved", gs, 1'b1);
    $display("Test write and safe done");
    boost = 1'b1;
    p.irun = 4'h5;
    p.ihold = 4'h3;
    lin.send(1'b1, p, 4'h0);
    run = 1'b1;
    repeat (3) @(negedge clk);
    chk("run_boost", {ci, cb}, {4'h5, 1'b1});
    run = 1'b0;
    repeat (3) @(negedge clk);
    chk("hold_index", ci, 4'h3);
    p.ihold = 4'hF;
    lin.send(1'b1, p, 4'h0);
    run = 1'b1;
    repeat (3) @(negedge clk);
    run = 1'b0;
    repeat (3) @(negedge clk);
    chk("zero_lowest", {ci, pwm, gnd}, {4'h0, 2'b10});
    repeat (115) @(negedge clk);
    chk("zero_off", {ci, pwm, gnd}, {4'h0, 2'b01});
    run = 1'b1;
    repeat (2) @(negedge clk);
    chk("restart_run", {ci, pwm, gnd}, {4'h5, 2'b10});
    $display("Test coil current done");
    for (int s = 0; s < 2; s++)
    begin
      p.auto_sleep_allow = 1'(s);
      lin.send(1'b1, p, 4'h0);
      lin.send(1'b0, p, 4'h8);
      chk("timeout", {slp, hsr}, {1'(s), 1'(1 - s)});
    end
    ce = 1'b0;
    ep = p;
    p.irun = ~p.irun;
    lin.send(1'b1, p, 4'h0);
    chk("ce_frozen", op, ep);
    ce = 1'b1;
    p = ep;
    $display("Test timeout done");
    img[3] = ~img[3];
    img[0][7] = 1'b0;
    repeat (3) @(negedge clk);
    chk("no_reload", op, p);
    do_reset();
    rbq.push_back(img[5]);
    rbq.push_back(img[6]);
    lin.burst_read(5, 6);
    repeat (2) @(negedge clk);
    chk("bank_clear_read", rbq.size(), 0);
    $display("Test reload done");
    tally_and_finish();
  end
endmodule : oapd_loader_tb
